/* flash_cmd_pkg.sv */
// constants and types shared by the flash command decoder
package flash_cmd_pkg;
  localparam logic [11:0] UNLOCK_ADDR_ONE = 12'h555;
  localparam logic [11:0] UNLOCK_ADDR_TWO = 12'haaa;
  localparam logic [7:0]  UNLOCK_DATA_ONE = 8'haa;
  localparam logic [7:0]  UNLOCK_DATA_TWO = 8'h55;
  localparam logic [7:0]  CMD_READ_ID     = 8'h90;
  localparam logic [7:0]  CMD_PROGRAM     = 8'ha0;
  localparam logic [7:0]  CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0]  CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0]  CMD_BULK_ERASE  = 8'h10;
  localparam logic [7:0]  CMD_SUSPEND     = 8'hb0;
  localparam logic [7:0]  CMD_RESUME      = 8'h30;
  localparam logic [7:0]  CMD_RESET       = 8'hf0;
  localparam logic [7:0]  CMD_BYPASS      = 8'h20;
  localparam logic [7:0]  CMD_BYPASS_EXIT = 8'h00;
  localparam logic [11:0] ID_OFFSET       = 12'h001;
  localparam logic [11:0] PROT_OFFSET     = 12'h002;
  localparam logic [7:0]  PROT_YES        = 8'h01;
  localparam logic [7:0]  PROT_NO         = 8'h00;
  localparam int          ADDR_LOW_BITS   = 12;
  localparam int          TIMEOUT_CYCLES_DEFAULT = 2000;
  localparam int          PAGE_BIT_FOUR   = 4;

  typedef enum logic [10:0] {
    ST_READ     = 11'h001,
    ST_UNLOCK1  = 11'h002,
    ST_UNLOCK2  = 11'h004,
    ST_ID_MODE  = 11'h008,
    ST_PROG     = 11'h010,
    ST_ERASE_U0 = 11'h020,
    ST_ERASE_U1 = 11'h040,
    ST_ERASE_U2 = 11'h080,
    ST_SECT_ADD = 11'h100,
    ST_BYPASS   = 11'h200,
    ST_BYP_CMD  = 11'h400
  } dec_state_t;
endpackage

/* flash_op_if.sv */
// request and status bundle between decoder and operation tracker
`timescale 1ns/100ps
interface flash_op_if;
  logic       startProgram;
  logic       startSectorErase;
  logic       startBulkErase;
  logic       addSector;
  logic       suspend;
  logic       resume;
  logic       sectorErasing;
  logic       suspended;
  logic       busy;
  modport decoder (output startProgram, startSectorErase, startBulkErase, addSector,
                   suspend, resume, input sectorErasing, suspended, busy);
  modport tracker (input startProgram, startSectorErase, startBulkErase, addSector,
                   suspend, resume, output sectorErasing, suspended, busy);
endinterface

/* flash_op_tracker.sv */
// tracks a running program or erase operation and its completion
`timescale 1ns/100ps
module flash_op_tracker
  import flash_cmd_pkg::*;
#(
  parameter int PROG_CYCLES  = 16,
  parameter int ERASE_CYCLES = 64
) (
  input  wire logic  clk,        // device clock
  input  wire logic  rst_n,      // synchronous reset
  input  wire logic  opDone,     // early completion from array
  flash_op_if.tracker op         // decoder requests
);
  logic [15:0] remain;
  logic        erasing;
  logic        halted;

  assign op.sectorErasing = erasing;
  assign op.suspended     = halted;
  assign op.busy          = (remain != 16'h0000) && !halted;

  // counts stand in for the embedded algorithm, which lies outside
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      remain <= 16'h0000;
    end else if (op.startProgram) begin
      remain <= 16'(PROG_CYCLES);
    end else if (op.startSectorErase || op.startBulkErase || op.addSector) begin
      remain <= 16'(ERASE_CYCLES);
    end else if (opDone) begin
      remain <= 16'h0000;
    end else if (remain != 16'h0000 && !halted) begin
      remain <= remain - 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      erasing <= 1'b0;
    end else if (op.startSectorErase) begin
      erasing <= 1'b1;
    end else if (remain == 16'h0001 || opDone || op.startProgram || op.startBulkErase) begin
      erasing <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      halted <= 1'b0;
    end else if (op.suspend && erasing) begin
      halted <= 1'b1;
    end else if (op.resume && halted) begin
      halted <= 1'b0;
    end
  end
endmodule // flash_op_tracker

/* flash_command_decoder.sv */
// flash instruction decoder with upper block select and ready/busy
// Function
// - upper block address drives main array bit 15 when configured
// - without that equation, bus address bit 15 feeds main array
// - page bit four zero picks lower half, one picks upper half
// - upper block select covers all sectors, never sector erase addressing
// - ready/busy low during program or erase, high otherwise
// - flash writes are decoded as instruction steps, never stored
// - instruction executes only when complete and no gap timed out
// - invalid byte or time-out returns decoder to read-array mode
// - address bits 15..12 ignored; host keeps sector select asserted
// - main or secondary array chosen by its selects; ID only main
// - after unlock and 90, read at offset 01 returns identifier
// - after unlock and 90, offset 02 returns protection 01 or 00
// - after unlock and A0, next write programs its byte
// - unlock, 80, unlock, 30 at sector erases; more 30 add sectors
// - B0 suspends running sector erase; 30 resumes it
// - F0 anywhere outside bypass returns decoder to read-array mode
// - unlock and 20 enters bypass; 90 then 00 leaves it
// - in bypass, A0 then data programs the byte without unlock
// - program address taken at strobe fall, data at strobe rise
// - suspend honoured only while a sector erase runs
`timescale 1ns/100ps
module flash_command_decoder
  import flash_cmd_pkg::*;
#(
  parameter int          TIMEOUT_CYCLES = TIMEOUT_CYCLES_DEFAULT,
  parameter int          PROG_CYCLES    = 16,
  parameter int          ERASE_CYCLES   = 64,
  parameter logic [7:0]  MAIN_ID        = 8'h5a  // arbitrary value
) (
  input  wire logic        clk,                     // device clock
  input  wire logic        rst_n,                   // synchronous reset, active low
  input  wire logic [15:0] busAddr,                 // microcontroller address
  input  wire logic [7:0]  busData,                 // microcontroller write data
  input  wire logic        control_input_zero,      // write strobe, active low
  input  wire logic        readStrobe,              // read cycle, one-cycle pulse
  input  wire logic [7:0]  main_sector_select,      // main sector selects, high
  input  wire logic [3:0]  secondary_sector_select, // secondary selects, high
  input  wire logic [7:0]  pageReg,                 // page register value
  input  wire logic        upperBlockEn,            // upper block equation configured
  input  wire logic        sectorProtected,         // addressed sector protected
  input  wire logic        opDone,                  // array reports completion
  output logic             upper_block_addr,        // main array address bit 15
  output logic             ready_busy_pin,          // 1 ready, 0 busy
  output logic             readArrayMode,           // reads pass to array as ROM
  output logic [7:0]       specialData,             // ID or protection byte
  output logic             specialValid,            // specialData is for this read
  output logic             progReq,                 // program one byte pulse
  output logic [15:0]      program_addr,            // program target address
  output logic [7:0]       program_byte,            // program data byte
  output logic             eraseReq,                // erase request pulse
  output logic             eraseBulk,               // erase covers whole array
  output logic [15:0]      erase_sector_addr,       // sector erase address
  output logic             targetMain               // 1 main, 0 secondary array
);
  flash_op_if op ();

  flash_op_tracker #(
    .PROG_CYCLES  (PROG_CYCLES),
    .ERASE_CYCLES (ERASE_CYCLES)
  ) u_tracker (
    .clk    (clk),
    .rst_n  (rst_n),
    .opDone (opDone),
    .op     (op.tracker)
  );

  dec_state_t  state;
  logic        strobePrev;
  logic        wrFall;
  logic        wrRise;
  logic        mainSel;
  logic        anySel;
  logic [11:0] lowAddr;
  logic [15:0] capAddr;
  logic        timedOut;
  logic [31:0] gapCount;
  logic        inBypass;
  logic        pendingProgram;
  logic        idFromMain;

  function automatic logic at_addr(input logic [11:0] a, input logic [11:0] ref_a);
    at_addr = (a == ref_a);
  endfunction

  assign mainSel = |main_sector_select;
  assign anySel  = mainSel || (|secondary_sector_select);
  assign wrFall  = strobePrev && !control_input_zero;
  assign wrRise  = !strobePrev && control_input_zero && anySel;
  assign lowAddr = capAddr[ADDR_LOW_BITS-1:0];
  assign timedOut = (gapCount >= 32'(TIMEOUT_CYCLES));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      strobePrev <= 1'b1;
    end else begin
      strobePrev <= control_input_zero;
    end
  end

  // address latched at strobe fall, data used at strobe rise
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      capAddr <= 16'h0000;
    end else if (wrFall) begin
      capAddr <= busAddr;
    end
  end

  // gap counter restarts on every accepted byte
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gapCount <= 32'h00000000;
    end else if (wrRise) begin
      gapCount <= 32'h00000000;
    end else if (!timedOut) begin
      gapCount <= gapCount + 32'h00000001;
    end
  end

  // upper block select; sector erase addressing uses the raw bus bit 15
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      upper_block_addr <= 1'b0;
    end else if (upperBlockEn) begin
      upper_block_addr <= pageReg[PAGE_BIT_FOUR];
    end else begin
      upper_block_addr <= busAddr[15];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ready_busy_pin <= 1'b1;
    end else begin
      ready_busy_pin <= !(op.busy || progReq || eraseReq);
    end
  end

  // main sequencer: every write is a step, never a store
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state          <= ST_READ;
      inBypass       <= 1'b0;
      pendingProgram <= 1'b0;
      idFromMain     <= 1'b0;
      targetMain     <= 1'b1;
    end else if (timedOut && state != ST_READ && state != ST_ID_MODE
                 && state != ST_BYPASS) begin
      state          <= inBypass ? ST_BYPASS : ST_READ;
      pendingProgram <= 1'b0;
    end else if (wrRise) begin
      targetMain <= mainSel;
      if (busData == CMD_RESET && !inBypass) begin
        state <= ST_READ;
      end else begin
        unique case (state)
          ST_READ, ST_ID_MODE, ST_SECT_ADD: begin
            if (busData == UNLOCK_DATA_ONE && at_addr(lowAddr, UNLOCK_ADDR_ONE)) begin
              state <= ST_UNLOCK1;
            end else if (state == ST_SECT_ADD && busData == CMD_SECTOR_ERASE) begin
              state <= ST_SECT_ADD;
            end else begin
              state <= ST_READ;
            end
          end
          ST_UNLOCK1: begin
            if (busData == UNLOCK_DATA_TWO && at_addr(lowAddr, UNLOCK_ADDR_TWO)) begin
              state <= ST_UNLOCK2;
            end else begin
              state <= ST_READ;
            end
          end
          ST_UNLOCK2: begin
            if (!at_addr(lowAddr, UNLOCK_ADDR_ONE)) begin
              state <= ST_READ;
            end else if (busData == CMD_READ_ID) begin
              state      <= ST_ID_MODE;
              idFromMain <= mainSel;
            end else if (busData == CMD_PROGRAM) begin
              state <= ST_PROG;
            end else if (busData == CMD_ERASE_SETUP) begin
              state <= ST_ERASE_U0;
            end else if (busData == CMD_BYPASS) begin
              state    <= ST_BYPASS;
              inBypass <= 1'b1;
            end else begin
              state <= ST_READ;
            end
          end
          ST_PROG: begin
            state <= inBypass ? ST_BYPASS : ST_READ;
          end
          ST_ERASE_U0: begin
            state <= (busData == UNLOCK_DATA_ONE && at_addr(lowAddr, UNLOCK_ADDR_ONE))
                     ? ST_ERASE_U1 : ST_READ;
          end
          ST_ERASE_U1: begin
            state <= (busData == UNLOCK_DATA_TWO && at_addr(lowAddr, UNLOCK_ADDR_TWO))
                     ? ST_ERASE_U2 : ST_READ;
          end
          ST_ERASE_U2: begin
            if (busData == CMD_SECTOR_ERASE) begin
              state <= ST_SECT_ADD;
            end else begin
              state <= ST_READ; // bulk erase and bad confirm both end here
            end
          end
          ST_BYPASS: begin
            if (busData == CMD_PROGRAM) begin
              state <= ST_PROG;
            end else if (busData == CMD_READ_ID) begin
              state <= ST_BYP_CMD;
            end
          end
          ST_BYP_CMD: begin
            if (busData == CMD_BYPASS_EXIT) begin
              state    <= ST_READ;
              inBypass <= 1'b0;
            end else begin
              state <= ST_BYPASS;
            end
          end
        endcase
      end
    end
  end

  // operation launches; pulses last one clock
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      progReq           <= 1'b0;
      eraseReq          <= 1'b0;
      eraseBulk         <= 1'b0;
      program_addr      <= 16'h0000;
      program_byte      <= 8'h00;
      erase_sector_addr <= 16'h0000;
    end else begin
      progReq  <= 1'b0;
      eraseReq <= 1'b0;
      if (wrRise && !timedOut && state == ST_PROG) begin
        progReq      <= 1'b1;
        program_addr <= capAddr;
        program_byte <= busData;
      end
      if (wrRise && !timedOut && state == ST_ERASE_U2 && busData == CMD_BULK_ERASE
          && at_addr(lowAddr, UNLOCK_ADDR_ONE)) begin
        eraseReq  <= 1'b1;
        eraseBulk <= 1'b1;
      end
      if (wrRise && !timedOut && busData == CMD_SECTOR_ERASE
          && (state == ST_ERASE_U2 || state == ST_SECT_ADD)) begin
        eraseReq          <= 1'b1;
        eraseBulk         <= 1'b0;
        erase_sector_addr <= capAddr;
      end
    end
  end

  assign op.startProgram     = progReq;
  assign op.startBulkErase   = eraseReq && eraseBulk;
  assign op.startSectorErase = eraseReq && !eraseBulk && !op.sectorErasing;
  assign op.addSector        = eraseReq && !eraseBulk && op.sectorErasing;
  assign op.suspend = wrRise && busData == CMD_SUSPEND;
  assign op.resume  = wrRise && busData == CMD_RESUME && op.suspended && state == ST_READ;

  // read path: special bytes while in identifier mode
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      specialData   <= 8'h00;
      specialValid  <= 1'b0;
      readArrayMode <= 1'b1;
    end else begin
      readArrayMode <= (state == ST_READ) || (state == ST_BYPASS);
      specialValid  <= 1'b0;
      if (readStrobe && state == ST_ID_MODE) begin
        if (at_addr(busAddr[ADDR_LOW_BITS-1:0], ID_OFFSET) && idFromMain) begin
          specialData  <= MAIN_ID;
          specialValid <= 1'b1;
        end else if (at_addr(busAddr[ADDR_LOW_BITS-1:0], PROT_OFFSET)) begin
          specialData  <= sectorProtected ? PROT_YES : PROT_NO;
          specialValid <= 1'b1;
        end
      end
    end
  end
endmodule // flash_command_decoder

/* flash_decoder_checker.sv */
// port assertions for the flash command decoder
`timescale 1ns/100ps
module flash_decoder_checker (
  input wire logic        clk,                     // device clock
  input wire logic        rst_n,                   // synchronous reset, active low
  input wire logic [15:0] busAddr,                 // bus address
  input wire logic [7:0]  busData,                 // bus write data
  input wire logic        control_input_zero,      // write strobe, active low
  input wire logic        readStrobe,              // read pulse
  input wire logic [7:0]  main_sector_select,      // main selects
  input wire logic [3:0]  secondary_sector_select, // secondary selects
  input wire logic [7:0]  pageReg,                 // page register
  input wire logic        upperBlockEn,            // equation configured
  input wire logic        upper_block_addr,        // main array bit 15
  input wire logic        ready_busy_pin,          // 1 ready, 0 busy
  input wire logic        readArrayMode,           // read array mode
  input wire logic        specialValid,            // special read valid
  input wire logic        progReq,                 // program pulse
  input wire logic [7:0]  program_byte,            // program data
  input wire logic        eraseReq,                // erase pulse
  input wire logic        targetMain               // 1 main array
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  upper_from_page_a:
    assert property ($past(rst_n) && $past(upperBlockEn) |-> upper_block_addr == $past(pageReg[4]))
    else $error("upper block bit does not follow page bit four");
  upper_from_bus_a:
    assert property ($past(rst_n) && !$past(upperBlockEn) |-> upper_block_addr == $past(busAddr[15]))
    else $error("upper block bit does not follow bus bit 15");
  reset_state_a:
    assert property (disable iff (1'b0) !rst_n |=> ready_busy_pin && readArrayMode && !upper_block_addr)
    else $error("outputs not at reset values");
  prog_launch_a:
    assert property (progReq |-> $past(control_input_zero) && !$past(control_input_zero, 2)
                     && program_byte == $past(busData))
    else $error("program request without a strobe rise carrying its byte");
  prog_select_a:
    assert property (progReq |-> (|$past(main_sector_select)) || (|$past(secondary_sector_select)))
    else $error("program request without a sector select");
  erase_launch_a:
    assert property (eraseReq |-> $past(control_input_zero) && !$past(control_input_zero, 2)
                     && targetMain == (|$past(main_sector_select)))
    else $error("erase request timing or target wrong");
  special_read_a:
    assert property (specialValid |-> $past(readStrobe) ##1 !specialValid)
    else $error("special data valid without a read pulse");
  busy_prog_a:
    assert property (progReq |=> !ready_busy_pin [*2])
    else $error("not busy after program launch");
  busy_erase_a:
    assert property (eraseReq |=> !ready_busy_pin)
    else $error("not busy after erase launch");
  cover property (progReq);
  cover property (eraseReq && targetMain);
  cover property (eraseReq && !targetMain);
  cover property (specialValid);
endmodule // flash_decoder_checker

bind flash_command_decoder flash_decoder_checker chk (
  .clk(clk), .rst_n(rst_n), .busAddr(busAddr), .busData(busData),
  .control_input_zero(control_input_zero), .readStrobe(readStrobe),
  .main_sector_select(main_sector_select), .secondary_sector_select(secondary_sector_select),
  .pageReg(pageReg), .upperBlockEn(upperBlockEn), .upper_block_addr(upper_block_addr),
  .ready_busy_pin(ready_busy_pin), .readArrayMode(readArrayMode), .specialValid(specialValid),
  .progReq(progReq), .program_byte(program_byte), .eraseReq(eraseReq), .targetMain(targetMain)
);

/* mcu_bus_model.sv */
// microcontroller model issuing flash bus write and read cycles
`timescale 1ns/100ps
module mcu_bus_model
  import flash_cmd_pkg::*;
(
  input  wire logic        clk,        // device clock
  output logic      [15:0] busAddr,    // bus address
  output logic      [7:0]  busData,    // write data
  output logic             wrStrobeN,  // write strobe, active low
  output logic             readStrobe, // read pulse
  output logic      [7:0]  mainSel,    // main sector selects
  output logic      [3:0]  secSel      // secondary sector selects
);
  initial begin
    busAddr    = 16'h0000;
    busData    = 8'h00;
    wrStrobeN  = 1'b1;
    readStrobe = 1'b0;
    mainSel    = 8'h01;
    secSel     = 4'h0;
  end
  // selects held across the whole instruction
  task automatic sel(input logic [7:0] m, input logic [3:0] s);
    @(posedge clk);
    mainSel <= m;
    secSel  <= s;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    wrStrobeN <= 1'b0;
    busAddr   <= a;
    busData   <= ~busData; // stale byte never looks valid
    @(posedge clk);
    wrStrobeN <= 1'b1;
    busData   <= d;
    busAddr   <= ~a; // address only counts at the fall
  endtask
  task automatic unlock();
    wr({4'hc, UNLOCK_ADDR_ONE}, UNLOCK_DATA_ONE);
    wr({4'h3, UNLOCK_ADDR_TWO}, UNLOCK_DATA_TWO);
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge clk);
    readStrobe <= 1'b1;
    busAddr    <= a;
    @(posedge clk);
    readStrobe <= 1'b0;
  endtask
endmodule // mcu_bus_model

/* flash_command_decoder_test.sv */
// self-checking testbench for the flash command decoder
`timescale 1ns/100ps
module flash_command_decoder_test;
  import flash_cmd_pkg::*;
  localparam int         TOUT  = 20;
  localparam int         PROG  = 16;
  localparam int         ERASE = 64;
  localparam logic [7:0] ID    = 8'h3c; // arbitrary value
  logic clk, rst_n, upperBlockEn, sectorProtected, opDone, wrN, rdS;
  logic [15:0] busAddr, program_addr, erase_sector_addr;
  logic [7:0]  busData, mainSel, pageReg, specialData, program_byte;
  logic [3:0]  secSel;
  logic        upper_block_addr, ready_busy_pin, readArrayMode, specialValid;
  logic        progReq, eraseReq, eraseBulk, targetMain;
  int          miscompares, testsRun, progCount, eraseCount;

  mcu_bus_model mcu (.clk(clk), .busAddr(busAddr), .busData(busData), .wrStrobeN(wrN),
                     .readStrobe(rdS), .mainSel(mainSel), .secSel(secSel));
  flash_command_decoder #(.TIMEOUT_CYCLES(TOUT), .PROG_CYCLES(PROG), .ERASE_CYCLES(ERASE),
                          .MAIN_ID(ID)) DUT (
    .clk(clk), .rst_n(rst_n), .busAddr(busAddr), .busData(busData),
    .control_input_zero(wrN), .readStrobe(rdS), .main_sector_select(mainSel),
    .secondary_sector_select(secSel), .pageReg(pageReg), .upperBlockEn(upperBlockEn),
    .sectorProtected(sectorProtected), .opDone(opDone), .upper_block_addr(upper_block_addr),
    .ready_busy_pin(ready_busy_pin), .readArrayMode(readArrayMode), .specialData(specialData),
    .specialValid(specialValid), .progReq(progReq), .program_addr(program_addr),
    .program_byte(program_byte), .eraseReq(eraseReq), .eraseBulk(eraseBulk),
    .erase_sector_addr(erase_sector_addr), .targetMain(targetMain));

  always #20 clk = ~clk;
  always @(posedge clk) begin
    if (progReq === 1'b1) progCount++;
    if (eraseReq === 1'b1) eraseCount++;
  end

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    testsRun++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic waitReady(input int n);
    for (int k = 0; k < n && ready_busy_pin !== 1'b1; k++) @(posedge clk);
    #1;
    chk("ready", 16'h1, {15'h0, ready_busy_pin});
  endtask
  task automatic eraseSetup();
    mcu.unlock();
    mcu.wr({4'h5, UNLOCK_ADDR_ONE}, CMD_ERASE_SETUP);
    mcu.unlock();
  endtask
  task automatic tUpper();
    mcu.rd(16'h8000);
    settle();
    chk("ubaBus", 16'h1, {15'h0, upper_block_addr});
    @(posedge clk);
    upperBlockEn <= 1'b1;
    pageReg      <= 8'h10;
    settle();
    chk("ubaPage1", 16'h1, {15'h0, upper_block_addr});
    @(posedge clk) pageReg <= 8'h00;
    settle();
    chk("ubaPage0", 16'h0, {15'h0, upper_block_addr});
    @(posedge clk) pageReg <= 8'h10;
  endtask
  task automatic tProgram(input int gap, input int dp);
    int p;
    p = progCount;
    mcu.unlock();
    repeat (gap) @(posedge clk);
    mcu.wr({4'h7, UNLOCK_ADDR_ONE}, CMD_PROGRAM);
    mcu.wr(16'hf123, 8'h3c);
    settle();
    chk("progCount", 16'(p + dp), 16'(progCount));
    if (dp == 1) begin
      chk("progAddr", 16'hf123, program_addr);
      chk("progByte", 16'h3c, {8'h0, program_byte});
      chk("busy", 16'h0, {15'h0, ready_busy_pin});
      waitReady(PROG + 8);
    end
  endtask
  task automatic tSpecial();
    mcu.unlock();
    mcu.wr({4'h0, UNLOCK_ADDR_ONE}, CMD_READ_ID);
    settle();
    chk("idMode", 16'h0, {15'h0, readArrayMode});
    for (int i = 0; i < 3; i++) begin
      @(posedge clk) sectorProtected <= (i == 1);
      mcu.rd({4'h3, (i == 0) ? ID_OFFSET : PROT_OFFSET});
      #1;
      chk("specValid", 16'h1, {15'h0, specialValid});
      chk("specData", {8'h0, (i == 0) ? ID : (i == 1) ? PROT_YES : PROT_NO},
          {8'h0, specialData});
    end
    mcu.wr(16'h4321, CMD_RESET);
    settle();
    chk("readMode", 16'h1, {15'h0, readArrayMode});
    // identifier read is refused by the secondary array
    mcu.sel(8'h00, 4'h1);
    mcu.unlock();
    mcu.wr(16'h0555, CMD_READ_ID);
    mcu.rd(16'h0001);
    #1;
    chk("secId", 16'h0, {15'h0, specialValid});
    mcu.wr(16'h0000, CMD_RESET);
    mcu.sel(8'h01, 4'h0);
  endtask
  task automatic tErase();
    int e;
    e = eraseCount;
    mcu.wr(16'h0123, CMD_SUSPEND);
    settle();
    chk("idleSuspend", 16'h1, {15'h0, ready_busy_pin});
    mcu.sel(8'h00, 4'h2);
    eraseSetup();
    mcu.wr(16'h4200, CMD_SECTOR_ERASE);
    settle();
    chk("eraseCount", 16'(e + 1), 16'(eraseCount));
    chk("eraseAddr", 16'h4200, erase_sector_addr);
    chk("eraseBulk", 16'h0, {15'h0, eraseBulk});
    chk("target", 16'h0, {15'h0, targetMain});
    mcu.wr(16'h0000, CMD_SUSPEND);
    repeat (ERASE + 10) @(posedge clk);
    mcu.wr(16'h0000, CMD_RESUME);
    settle();
    chk("resumedBusy", 16'h0, {15'h0, ready_busy_pin});
    @(posedge clk) opDone <= 1'b1;
    @(posedge clk) opDone <= 1'b0;
    waitReady(4);
    mcu.sel(8'h80, 4'h0);
    eraseSetup();
    mcu.wr({4'h9, UNLOCK_ADDR_ONE}, CMD_BULK_ERASE);
    settle();
    chk("bulkCount", 16'(e + 2), 16'(eraseCount));
    chk("bulk", 16'h1, {15'h0, eraseBulk});
    chk("targetMain", 16'h1, {15'h0, targetMain});
    waitReady(ERASE + 8);
  endtask
  task automatic tBypass();
    int p;
    p = progCount;
    mcu.unlock();
    mcu.wr({4'h0, UNLOCK_ADDR_ONE}, CMD_BYPASS);
    mcu.wr(16'h0777, CMD_PROGRAM);
    mcu.wr(16'h1234, 8'h5e);
    settle();
    chk("bypProg", 16'(p + 1), 16'(progCount));
    chk("bypByte", 16'h5e, {8'h0, program_byte});
    waitReady(PROG + 8);
    mcu.wr(16'h0001, CMD_READ_ID);
    mcu.wr(16'h0002, CMD_BYPASS_EXIT);
    mcu.wr(16'h0777, CMD_PROGRAM);
    mcu.wr(16'h1235, 8'h5f);
    settle();
    chk("bypExit", 16'(p + 1), 16'(progCount));
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    #(40 * 20000);
    miscompares++;
    $display("MISMATCH watchdog expected done seen hang");
    finish_test();
  end
  initial begin
    {clk, rst_n, upperBlockEn, sectorProtected, opDone} = 5'b0;
    pageReg = 8'h00;
    repeat (10) @(posedge clk);
    chk("resetReady", 16'h1, {15'h0, ready_busy_pin});
    chk("resetRead", 16'h1, {15'h0, readArrayMode});
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    tUpper();
    tProgram(0, 1);
    tProgram(TOUT - 8, 1);
    tProgram(TOUT + 5, 0);
    mcu.wr({4'h0, UNLOCK_ADDR_ONE}, UNLOCK_DATA_ONE);
    mcu.wr({4'h0, UNLOCK_ADDR_TWO}, 8'h12);
    tProgram(0, 1);
    mcu.sel(8'h00, 4'h0);
    tProgram(0, 0);
    mcu.sel(8'h01, 4'h0);
    tSpecial();
    tErase();
    tBypass();
    finish_test();
  end
endmodule // flash_command_decoder_test
